// ===== logic/spread_modem_defines.vh
// Register offsets, field positions, reset values and decode constants
`ifndef SPREAD_MODEM_DEFINES_VH
`define SPREAD_MODEM_DEFINES_VH

// Register offsets on the configuration port
`define OFS_FIFO_DATA     7'h00
`define OFS_OP_MODE       7'h01
`define OFS_FIFO_PTR      7'h0d
`define OFS_STATUS        7'h18
`define OFS_CFG1          7'h1d
`define OFS_CFG2          7'h1e
`define OFS_DET_TUNE      7'h31
`define OFS_DET_THR       7'h37

// Operating mode register fields
`define OPM_LR_BIT        7
`define OPM_MODE_MSB      2
`define OPM_MODE_LSB      0
`define MODE_SLEEP        3'h0
`define MODE_STANDBY      3'h1

// First modem config register fields
`define CFG1_BW_MSB       7
`define CFG1_BW_LSB       6
`define CFG1_CR_MSB       5
`define CFG1_CR_LSB       3
`define CFG1_IMPL_BIT     2
`define CFG1_CRC_BIT      1

// Second modem config register fields
`define CFG2_SF_MSB       7
`define CFG2_SF_LSB       4

// Detection tuning field
`define DTUNE_MSB         2
`define DTUNE_LSB         0

// Status register bits
`define STAT_SF6_ERR_BIT  0
`define STAT_LR_BIT       1
`define STAT_REFUSED_BIT  2

// Legal field ranges
`define SF_MIN            4'h6
`define SF_MAX            4'hc
`define CR_MIN            3'h1
`define CR_MAX            3'h4
`define BW_MAX            2'h2

// Values the SF6 case calls for
`define DTUNE_SF6         3'h5
`define DTHR_SF6          8'h0c

// Reset values
`define RST_OP_MODE       8'h01
`define RST_SF            4'h7
`define RST_CR            3'h1
`define RST_BW            2'h0
`define RST_DTUNE         3'h3
`define RST_DTHR          8'h0a
`define RST_FSK_CFG       8'h00

// Double-sideband bandwidths in Hz
`define BW_125K_HZ        19'h1e848
`define BW_250K_HZ        19'h3d090
`define BW_500K_HZ        19'h7a120

`endif

// ===== logic/spread_param_decode.v
// Registered decode of spreading factor, coding rate and bandwidth
`timescale 1ns/1ps
`include "spread_modem_defines.vh"

module spread_param_decode (
	input  wire        CLK,
	input  wire        RST_B,
	input  wire        CE,
	input  wire [3:0]  sf,
	input  wire [2:0]  cr,
	input  wire [1:0]  bw,
	output reg  [12:0] chips_per_symbol,
	output reg  [3:0]  cr_denom,
	output reg  [18:0] bw_dsb_hz,
	output reg  [18:0] bw_ssb_hz,
	output reg  [18:0] symbol_rate_hz
);

	reg [18:0] bw_hz;

	// Bandwidth code to total channel width
	always @* begin
		case (bw)
			2'h0:    bw_hz = `BW_125K_HZ;
			2'h1:    bw_hz = `BW_250K_HZ;
			default: bw_hz = `BW_500K_HZ;
		endcase
	end

	// One stage of flops so all decoded data leave from registers
	always @(posedge CLK) begin
		if (!RST_B) begin
			chips_per_symbol <= 13'h0000;
			cr_denom         <= 4'h0;
			bw_dsb_hz        <= 19'h00000;
			bw_ssb_hz        <= 19'h00000;
			symbol_rate_hz   <= 19'h00000;
		end else if (CE) begin
			chips_per_symbol <= 13'h0001 << sf;
			cr_denom         <= {1'b0, cr} + 4'h4;
			bw_dsb_hz        <= bw_hz;
			bw_ssb_hz        <= bw_hz >> 1;
			symbol_rate_hz   <= bw_hz >> sf;
		end
	end

endmodule

// ===== logic/spread_modem_param_config.v
// Spread-spectrum modem configuration registers, FIFO and parameter decode
//
// Implementation choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "spread_modem_defines.vh"

module spread_modem_param_config #(
	parameter FIFO_AW    = 8,
	parameter FIFO_DEPTH = 256
) (
	input  wire               CLK,
	input  wire               RST_B,
	input  wire               CE,
	input  wire [6:0]         ADDR,
	input  wire [7:0]         WDATA,
	input  wire               WR,
	input  wire               RD,
	output reg  [7:0]         RDATA,
	input  wire [FIFO_AW-1:0] MDM_FIFO_ADDR,
	input  wire [7:0]         MDM_FIFO_WDATA,
	input  wire               MDM_FIFO_WE,
	output reg  [7:0]         MDM_FIFO_RDATA,
	output wire               LONG_RANGE_ON,
	output wire [2:0]         OP_MODE,
	output wire [3:0]         SF_OUT,
	output wire [2:0]         CR_OUT,
	output wire [12:0]        CHIPS_PER_SYMBOL,
	output wire [3:0]         CR_DENOM,
	output wire               IMPLICIT_HDR,
	output wire               CRC_ON,
	output wire               HDR_CR_EN,
	output wire [2:0]         HDR_CR_FIELD,
	output wire [18:0]        BW_DSB_HZ,
	output wire [18:0]        BW_SSB_HZ,
	output wire [18:0]        SYMBOL_RATE_HZ,
	output wire [2:0]         DET_TUNE,
	output wire [7:0]         DET_THRESH,
	output wire               SF6_CFG_ERR,
	output wire [7:0]         FSK_CFG
);

	reg  [7:0]         op_mode_r;
	reg  [3:0]         sf_r;
	reg  [2:0]         cr_r;
	reg  [1:0]         bw_r;
	reg                impl_r;
	reg                crc_r;
	reg  [2:0]         dtune_r;
	reg  [7:0]         dthr_r;
	reg  [7:0]         fsk_cfg_r;
	reg  [FIFO_AW-1:0] fifo_ptr_r;
	reg                refused_r;
	reg                sf6_err_r;
	reg  [7:0]         fifo_mem [0:FIFO_DEPTH-1];
	reg  [7:0]         rdata_nxt;
	wire               lr_on;
	wire               asleep;
	wire               wr_op;
	wire               lr_change;
	wire               lr_wr;
	wire               lr_rd;
	wire               fifo_wr;
	wire               fifo_rd;

	// Registers that exist only in the long-range map
	function lr_only;
		input [6:0] a;
		begin
			lr_only = (a == `OFS_FIFO_DATA) || (a == `OFS_FIFO_PTR) ||
				(a == `OFS_CFG2) || (a == `OFS_DET_TUNE) ||
				(a == `OFS_DET_THR);
		end
	endfunction

	assign lr_on     = op_mode_r[`OPM_LR_BIT];
	assign asleep    = op_mode_r[`OPM_MODE_MSB:`OPM_MODE_LSB] == `MODE_SLEEP;
	assign wr_op     = CE && WR && (ADDR == `OFS_OP_MODE);
	assign lr_change = wr_op && (WDATA[`OPM_LR_BIT] != lr_on);
	// Long-range registers are invisible while the FSK map is active
	assign lr_wr     = CE && WR && lr_on;
	assign lr_rd     = CE && RD && lr_on;
	assign fifo_wr   = lr_wr && (ADDR == `OFS_FIFO_DATA);
	assign fifo_rd   = lr_rd && (ADDR == `OFS_FIFO_DATA);

	// Operating mode; the modem select bit moves only from sleep
	always @(posedge CLK) begin
		if (!RST_B) begin
			op_mode_r <= `RST_OP_MODE;
		end else if (wr_op) begin
			op_mode_r[`OPM_MODE_MSB:`OPM_MODE_LSB] <=
				WDATA[`OPM_MODE_MSB:`OPM_MODE_LSB];
			if (asleep) begin
				op_mode_r[`OPM_LR_BIT] <= WDATA[`OPM_LR_BIT];
			end
		end
	end

	// Refused modem switch is sticky; a new refusal beats the read clear
	always @(posedge CLK) begin
		if (!RST_B) begin
			refused_r <= 1'b0;
		end else if (CE) begin
			if (lr_change && !asleep) begin
				refused_r <= 1'b1;
			end else if (RD && ADDR == `OFS_STATUS) begin
				refused_r <= 1'b0;
			end
		end
	end

	// Config registers; out-of-range fields keep their old value
	always @(posedge CLK) begin
		if (!RST_B) begin
			sf_r      <= `RST_SF;
			cr_r      <= `RST_CR;
			bw_r      <= `RST_BW;
			impl_r    <= 1'b0;
			crc_r     <= 1'b0;
			dtune_r   <= `RST_DTUNE;
			dthr_r    <= `RST_DTHR;
			fsk_cfg_r <= `RST_FSK_CFG;
		end else if (CE && WR) begin
			if (!lr_on && ADDR == `OFS_CFG1) begin
				fsk_cfg_r <= WDATA;
			end
			if (lr_wr && ADDR == `OFS_CFG1) begin
				if (WDATA[`CFG1_BW_MSB:`CFG1_BW_LSB] <= `BW_MAX) begin
					bw_r <= WDATA[`CFG1_BW_MSB:`CFG1_BW_LSB];
				end
				if (WDATA[`CFG1_CR_MSB:`CFG1_CR_LSB] >= `CR_MIN &&
					WDATA[`CFG1_CR_MSB:`CFG1_CR_LSB] <= `CR_MAX) begin
					cr_r <= WDATA[`CFG1_CR_MSB:`CFG1_CR_LSB];
				end
				impl_r <= WDATA[`CFG1_IMPL_BIT];
				crc_r  <= WDATA[`CFG1_CRC_BIT];
			end
			if (lr_wr && ADDR == `OFS_CFG2 &&
				WDATA[`CFG2_SF_MSB:`CFG2_SF_LSB] >= `SF_MIN &&
				WDATA[`CFG2_SF_MSB:`CFG2_SF_LSB] <= `SF_MAX) begin
				sf_r <= WDATA[`CFG2_SF_MSB:`CFG2_SF_LSB];
			end
			if (lr_wr && ADDR == `OFS_DET_TUNE) begin
				dtune_r <= WDATA[`DTUNE_MSB:`DTUNE_LSB];
			end
			if (lr_wr && ADDR == `OFS_DET_THR) begin
				dthr_r <= WDATA;
			end
		end
	end

	// SF6 setup check: the host owns these settings, this only reports them
	always @(posedge CLK) begin
		if (!RST_B) begin
			sf6_err_r <= 1'b0;
		end else if (CE) begin
			if (sf_r == `SF_MIN) begin
				sf6_err_r <= !impl_r ||
					(dtune_r != `DTUNE_SF6) ||
					(dthr_r != `DTHR_SF6);
			end else begin
				sf6_err_r <= (dtune_r != `RST_DTUNE) ||
					(dthr_r != `RST_DTHR);
			end
		end
	end

	// FIFO pointer: host sets it, each data access steps it
	always @(posedge CLK) begin
		if (!RST_B) begin
			fifo_ptr_r <= {FIFO_AW{1'b0}};
		end else if (lr_wr && ADDR == `OFS_FIFO_PTR) begin
			fifo_ptr_r <= WDATA[FIFO_AW-1:0];
		end else if (fifo_wr || fifo_rd) begin
			fifo_ptr_r <= fifo_ptr_r + 1'b1;
		end
	end

	// Dual-port storage; on a same-address clash the host write lands last
	always @(posedge CLK) begin
		if (CE) begin
			if (MDM_FIFO_WE) begin
				fifo_mem[MDM_FIFO_ADDR] <= MDM_FIFO_WDATA;
			end
			if (fifo_wr) begin
				fifo_mem[fifo_ptr_r] <= WDATA;
			end
		end
	end

	// Modem-side read port, one cycle latency
	always @(posedge CLK) begin
		if (!RST_B) begin
			MDM_FIFO_RDATA <= 8'h00;
		end else if (CE) begin
			MDM_FIFO_RDATA <= fifo_mem[MDM_FIFO_ADDR];
		end
	end

	// Read mux; unmapped and hidden addresses read zero
	always @* begin
		rdata_nxt = 8'h00;
		if (lr_only(ADDR) && !lr_on) begin
			rdata_nxt = 8'h00;
		end else begin
			case (ADDR)
				`OFS_FIFO_DATA: rdata_nxt = fifo_mem[fifo_ptr_r];
				`OFS_OP_MODE:   rdata_nxt = op_mode_r;
				`OFS_FIFO_PTR:  rdata_nxt = {{(8-FIFO_AW){1'b0}}, fifo_ptr_r};
				`OFS_STATUS:    rdata_nxt = {5'h00, refused_r, lr_on,
					sf6_err_r};
				`OFS_CFG1: begin
					if (lr_on) begin
						rdata_nxt = {bw_r, cr_r, impl_r, crc_r, 1'b0};
					end else begin
						rdata_nxt = fsk_cfg_r;
					end
				end
				`OFS_CFG2:      rdata_nxt = {sf_r, 4'h0};
				`OFS_DET_TUNE:  rdata_nxt = {5'h00, dtune_r};
				`OFS_DET_THR:   rdata_nxt = dthr_r;
				default:        rdata_nxt = 8'h00;
			endcase
		end
	end

	// Read data stand for the one cycle after the strobe only
	always @(posedge CLK) begin
		if (!RST_B) begin
			RDATA <= 8'h00;
		end else if (CE) begin
			RDATA <= RD ? rdata_nxt : 8'h00;
		end
	end

	spread_param_decode u_decode (
		.CLK              (CLK),
		.RST_B            (RST_B),
		.CE               (CE),
		.sf               (sf_r),
		.cr               (cr_r),
		.bw               (bw_r),
		.chips_per_symbol (CHIPS_PER_SYMBOL),
		.cr_denom         (CR_DENOM),
		.bw_dsb_hz        (BW_DSB_HZ),
		.bw_ssb_hz        (BW_SSB_HZ),
		.symbol_rate_hz   (SYMBOL_RATE_HZ)
	);

	// Register-sourced status and config outputs
	assign LONG_RANGE_ON = lr_on;
	assign OP_MODE       = op_mode_r[`OPM_MODE_MSB:`OPM_MODE_LSB];
	assign SF_OUT        = sf_r;
	assign CR_OUT        = cr_r;
	assign IMPLICIT_HDR  = impl_r;
	assign CRC_ON        = crc_r;
	// Explicit headers carry the rate so the receiver can follow changes
	assign HDR_CR_EN     = !impl_r;
	assign HDR_CR_FIELD  = impl_r ? 3'h0 : cr_r;
	assign DET_TUNE      = dtune_r;
	assign DET_THRESH    = dthr_r;
	assign SF6_CFG_ERR   = sf6_err_r;
	assign FSK_CFG       = fsk_cfg_r;

endmodule

// ===== tb/spread_modem_props.sv
// Assertion checker for the spread modem configuration block
`timescale 1ns/1ps
module spread_modem_props (
	input wire        CLK,
	input wire        RST_B,
	input wire        RD,
	input wire [6:0]  ADDR,
	input wire [7:0]  RDATA,
	input wire        LONG_RANGE_ON,
	input wire [2:0]  OP_MODE,
	input wire [3:0]  SF_OUT,
	input wire [2:0]  CR_OUT,
	input wire [12:0] CHIPS_PER_SYMBOL,
	input wire [3:0]  CR_DENOM,
	input wire        IMPLICIT_HDR,
	input wire        HDR_CR_EN,
	input wire [2:0]  HDR_CR_FIELD,
	input wire [18:0] BW_DSB_HZ,
	input wire [18:0] BW_SSB_HZ,
	input wire [18:0] SYMBOL_RATE_HZ,
	input wire [2:0]  DET_TUNE,
	input wire [7:0]  DET_THRESH,
	input wire        SF6_CFG_ERR
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_B);
	// Fields never leave their legal ranges
	a_field_range: assert property (SF_OUT >= 4'h6 && SF_OUT <= 4'hc
		&& CR_OUT >= 3'h1 && CR_OUT <= 3'h4) else $error("field range");
	a_chips_pow: assert property (RST_B |=>
		CHIPS_PER_SYMBOL == (13'h1 << $past(SF_OUT))) else $error("chips");
	a_denom_cr: assert property (RST_B |=>
		CR_DENOM == $past(CR_OUT) + 4'h4) else $error("denominator");
	a_ssb_half: assert property (BW_SSB_HZ == (BW_DSB_HZ >> 1))
		else $error("ssb width");
	// Sampled reset gates the edge where reset lifts; past factor is unknown
	a_sym_rate: assert property (RST_B |-> SYMBOL_RATE_HZ ==
		(BW_DSB_HZ >> $past(SF_OUT))) else $error("symbol rate");
	a_hdr_rate: assert property (HDR_CR_EN == !IMPLICIT_HDR &&
		HDR_CR_FIELD == (IMPLICIT_HDR ? 3'h0 : CR_OUT)) else $error("hdr");
	// Mode swap only from sleep
	a_switch_sleep: assert property (RST_B && $changed(LONG_RANGE_ON) |->
		$past(OP_MODE) == 3'h0) else $error("switch outside sleep");
	a_fsk_map: assert property ($past(RD) && !$past(LONG_RANGE_ON) &&
		$past(ADDR) inside {7'h00, 7'h0d, 7'h1e, 7'h31, 7'h37}
		|-> RDATA == 8'h00) else $error("fsk map read");
	a_sf6_good: assert property (SF_OUT == 4'h6 && IMPLICIT_HDR &&
		DET_TUNE == 3'h5 && DET_THRESH == 8'h0c |=> !SF6_CFG_ERR)
		else $error("sf6 good flagged");
	a_sf6_expl: assert property (SF_OUT == 4'h6 && !IMPLICIT_HDR
		|=> SF6_CFG_ERR) else $error("sf6 explicit unflagged");
	a_dflt_back: assert property (SF_OUT != 4'h6 && DET_TUNE == 3'h3 &&
		DET_THRESH == 8'h0a |=> !SF6_CFG_ERR) else $error("defaults flagged");
endmodule
bind spread_modem_param_config spread_modem_props chk (.*);

// ===== tb/host_bus_model.sv
// Host controller model driving the configuration register port
`timescale 1ns/1ps
module host_bus_model (
	input  wire       clk,
	input  wire [7:0] rdata,
	output reg  [6:0] addr = 7'h00,
	output reg  [7:0] wdata = 8'h00,
	output reg        wr_stb = 1'b0,
	output reg        rd_stb = 1'b0
);
	// Bus lines scrambled once released, never left showing old values
	task put_reg(input [6:0] a, input [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge clk);
		wr_stb <= 1'b0;
		addr <= ~a;
		wdata <= ~d;
	endtask
	// Read data stands only in the cycle after the strobe
	task get_reg(input [6:0] a, output [7:0] d);
		@(posedge clk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge clk);
		rd_stb <= 1'b0;
		addr <= ~a;
		#1;
		d = rdata;
	endtask
	// Both link ends use this spreading factor, so host sets it first
	task sf6_setup;
		put_reg(7'h1e, 8'h60);
		put_reg(7'h1d, 8'h0c);
		put_reg(7'h31, 8'h05);
		put_reg(7'h37, 8'h0c);
	endtask
	task sf_restore(input [3:0] sf);
		put_reg(7'h1e, {sf, 4'h0});
		put_reg(7'h31, 8'h03);
		put_reg(7'h37, 8'h0a);
	endtask
endmodule

// ===== tb/spread_modem_param_config_test.sv
// Self-checking bench for the spread modem configuration block
`timescale 1ns/1ps
module spread_modem_param_config_test;
	reg         clk;
	reg         rst_b = 1'b0;
	reg  [7:0]  mfa = 8'h00;
	reg  [7:0]  mfd = 8'h00;
	reg         mfwe = 1'b0;
	reg         ce = 1'b1;
	wire        crc;
	wire [7:0]  fsk;
	wire [6:0]  addr;
	wire [7:0]  wdata, rdata, mfq;
	wire        wr, rd, lr, err;
	wire [12:0] chips;
	wire [3:0]  denom;
	wire [2:0]  hdr_cr;
	wire [18:0] dsb, ssb, sym;
	reg  [7:0]  d;
	integer     i, j, k, checked = 0, miscompares = 0, cycles = 0;
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	host_bus_model host (.clk(clk), .rdata(rdata), .addr(addr),
		.wdata(wdata), .wr_stb(wr), .rd_stb(rd));
	spread_modem_param_config dut (.CLK(clk), .RST_B(rst_b), .CE(ce),
		.ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
		.MDM_FIFO_ADDR(mfa), .MDM_FIFO_WDATA(mfd), .MDM_FIFO_WE(mfwe),
		.MDM_FIFO_RDATA(mfq), .LONG_RANGE_ON(lr), .OP_MODE(), .SF_OUT(),
		.CR_OUT(), .CHIPS_PER_SYMBOL(chips), .CR_DENOM(denom),
		.IMPLICIT_HDR(), .CRC_ON(crc), .HDR_CR_EN(), .HDR_CR_FIELD(hdr_cr),
		.BW_DSB_HZ(dsb), .BW_SSB_HZ(ssb), .SYMBOL_RATE_HZ(sym),
		.DET_TUNE(), .DET_THRESH(), .SF6_CFG_ERR(err), .FSK_CFG(fsk));
	task chk(input string n, input [18:0] e, input [18:0] g);
		checked = checked + 1;
		if (g !== e) begin
			miscompares = miscompares + 1;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	// Decode lags the register by one cycle
	task settle;
		repeat (2) @(posedge clk);
		#1;
	endtask
	task t_reset;
		chk("chips", 19'h80, chips);
		chk("sym", 19'h3d0, sym);
		chk("ssb", 19'hf424, ssb);
		host.get_reg(7'h1e, d);
		chk("fsk map", 19'h0, d);
		host.put_reg(7'h1d, 8'h3c);
		host.get_reg(7'h1d, d);
		chk("fsk cfg read", 19'h3c, d);
		chk("fsk cfg", 19'h3c, fsk);
		$display("test reset done");
	endtask
	task t_switch;
		host.put_reg(7'h01, 8'h81);
		settle;
		chk("lr refused", 19'h0, lr);
		host.put_reg(7'h01, 8'h00);
		host.put_reg(7'h01, 8'h81);
		settle;
		chk("lr on", 19'h1, lr);
		host.get_reg(7'h18, d);
		chk("status", 19'h6, d);
		$display("test switch done");
	endtask
	// Factor 13 is refused and the last legal value stays
	task t_sf;
		for (i = 6; i <= 13; i++) begin
			j = (i > 12) ? 12 : i;
			host.put_reg(7'h1e, {i[3:0], 4'h0});
			settle;
			chk("chips", 19'h1 << j, chips);
			chk("sym", 19'h1e848 >> j, sym);
		end
		$display("test sf done");
	endtask
	// Rate 0 and bandwidth code 3 keep the old value, other fields land
	task t_cr;
		for (k = 0; k <= 3; k++)
			for (i = 0; i <= 4; i++) begin
				host.put_reg(7'h1d, {k[1:0], i[2:0], 3'h0});
				settle;
				j = (i == 0) ? ((k == 0) ? 1 : 4) : i;
				chk("denom", j + 4, denom);
				chk("hdr cr", j, hdr_cr);
				chk("dsb", 19'h1e848 << (k == 3 ? 2 : k), dsb);
				chk("ssb", 19'hf424 << (k == 3 ? 2 : k), ssb);
			end
		$display("test cr done");
	endtask
	task t_sf6;
		host.sf6_setup;
		settle;
		chk("sf6 ok", 19'h0, err);
		chk("no hdr cr", 19'h0, hdr_cr);
		chk("crc off", 19'h0, crc);
		host.put_reg(7'h1d, 8'h0a);
		settle;
		chk("sf6 explicit", 19'h1, err);
		chk("crc on", 19'h1, crc);
		host.sf_restore(4'h8);
		settle;
		chk("defaults", 19'h0, err);
		$display("test sf6 done");
	endtask
	task t_fifo;
		host.put_reg(7'h0d, 8'h10);
		host.put_reg(7'h00, 8'ha5);
		host.put_reg(7'h00, 8'h5a);
		@(posedge clk);
		mfa <= 8'h11;
		@(posedge clk);
		mfa <= 8'h20;
		mfd <= 8'h3c;
		mfwe <= 1'b1;
		#1;
		chk("modem read", 19'h5a, mfq);
		@(posedge clk);
		mfwe <= 1'b0;
		host.put_reg(7'h0d, 8'h20);
		host.get_reg(7'h00, d);
		chk("host read", 19'h3c, d);
		host.get_reg(7'h0d, d);
		chk("pointer", 19'h21, d);
		$display("test fifo done");
	endtask
	// A write made while the clock enable is low must not land
	task t_hold;
		@(posedge clk);
		ce <= 1'b0;
		host.put_reg(7'h37, 8'h55);
		@(posedge clk);
		ce <= 1'b1;
		host.get_reg(7'h37, d);
		chk("ce hold", 19'h0a, d);
		$display("test hold done");
	endtask
	task report_and_stop;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Whole run needs well under a thousand cycles
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			miscompares = miscompares + 1;
			report_and_stop;
		end
	end
	initial begin
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		settle;
		t_reset;
		t_switch;
		t_sf;
		t_cr;
		t_sf6;
		t_fifo;
		t_hold;
		report_and_stop;
	end
endmodule
